/* File: rtl/teqc_pkg.sv */
// package: constants and types for the trigger and error queue control
package teqc_pkg;
	localparam int          ERR_DEPTH      = 8;
	localparam int          ERR_AW         = 3;
	localparam logic [15:0] ERR_NONE       = 16'h0000;
	// -350 in two's complement
	localparam logic [15:0] ERR_OVERFLOW   = 16'hFEA2;
	localparam logic [3:0]  ERR_CNT_RESET  = 4'h0;
	// supported language version, year then revision digit
	localparam logic [15:0] VER_YEAR       = 16'h07CF;
	localparam logic [3:0]  VER_REV        = 4'h0;
	localparam logic [1:0]  SEQ_TRANSIENT  = 2'h1;
	localparam logic [1:0]  SEQ_ACQUIRE    = 2'h2;
	localparam logic [1:0]  LANG_SCPI      = 2'h1;
	localparam logic [1:0]  SRC_BUS        = 2'h1;

	typedef enum logic [2:0] {
		TEQC_FN_VOLT = 3'h1,
		TEQC_FN_CURR = 3'h2,
		TEQC_FN_DVM  = 3'h4
	} teqc_func_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] code;
	} teqc_err_t;

	typedef struct packed {
		logic [15:0] year;
		logic [3:0]  rev;
	} teqc_ver_t;
endpackage : teqc_pkg

/* File: rtl/teqc_top.sv */
// trigger subsystem and remote error queue control
//
// Summary of operation
// - remote errors are appended to a FIFO queue as they happen.
// - an error query returns and removes the oldest queued error.
// - an empty queue answers an error query with code zero.
// - on overflow the last queue entry becomes the too-many-errors code.
// - front-panel errors bypass the queue and go straight to the display.
// - version query returns a year and single revision digit.
// - initiate and trigger address transient (1) and acquire (2) sequences.
// - abort cancels trigger actions and restores pending levels.
// - abort clears the waiting-for-trigger flag.
// - with continuous initiation, abort re-initiates and sets waiting again.
// - abort occurs at power-on, on recall and on reset command.
// - triggers to an uninitiated sequence are ignored.
// - continuous on keeps transient initiated; off needs initiate per trigger.
// - an accepted transient trigger starts the pending level change.
// - waiting flag is the OR of both sequences' waiting states.
// - after a transient trigger with continuous on, re-arm at once.
// - transient trigger source is fixed to bus and resets to bus.
// - an accepted acquire trigger starts a measurement with the selected function.
`timescale 1ns/1ps
`default_nettype none

module teqc_top
	import teqc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// error sources
	input  wire teqc_err_t   remote_err_i,
	input  wire teqc_err_t   panel_err_i,
	input  wire logic        err_query_i,
	output teqc_err_t        err_answer_o,
	output teqc_err_t        panel_disp_o,
	output logic [3:0]       err_count_o,
	// system queries
	output logic [1:0]       lang_sel_o,
	output teqc_ver_t        version_o,
	// trigger commands
	input  wire logic        init_cmd_i,
	input  wire logic [1:0]  init_seq_i,
	input  wire logic        trig_cmd_i,
	input  wire logic [1:0]  trig_seq_i,
	input  wire logic        abort_cmd_i,
	input  wire logic        recall_cmd_i,
	input  wire logic        reset_cmd_i,
	input  wire logic        continuous_initiation_setting_i,
	input  wire teqc_func_t  measurement_function_select_i,
	// trigger results
	output logic [1:0]       trig_source_o,
	output logic             level_change_o,
	output logic             level_restore_o,
	output logic             meas_start_o,
	output teqc_func_t       meas_func_o,
	output logic             tran_armed_o,
	output logic             acq_armed_o,
	output logic             waiting_for_trigger_flag_o
);

	////////////////////////////////////////////////////////////////////////
	// error queue

	teqc_err_t         queue [ERR_DEPTH];
	logic [ERR_AW-1:0] rd_ptr;
	logic [ERR_AW-1:0] wr_ptr;
	logic [3:0]        count;
	logic              do_pop;
	logic              do_push;
	logic              at_last;
	logic              full;

	assign do_pop  = err_query_i && (count != ERR_CNT_RESET);
	// one slot is held back for the overflow marker
	assign at_last = count == 4'(ERR_DEPTH - 1);
	assign full    = count == 4'(ERR_DEPTH);
	// later errors are dropped while full; a pop in the same cycle frees room
	assign do_push = remote_err_i.valid && (!full || do_pop);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
		end else if (do_push) begin
			wr_ptr <= wr_ptr + ERR_AW'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (do_push) begin
			queue[wr_ptr].valid <= 1'h1;
			// the final slot carries the overflow code instead
			if (at_last && !do_pop)
				queue[wr_ptr].code <= ERR_OVERFLOW;
			else
				queue[wr_ptr].code <= remote_err_i.code;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr <= '0;
		end else if (do_pop) begin
			rd_ptr <= rd_ptr + ERR_AW'(1);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= ERR_CNT_RESET;
		end else if (do_push && !do_pop) begin
			count <= count + 4'h1;
		end else if (do_pop && !do_push) begin
			count <= count - 4'h1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			err_answer_o <= '0;
		end else if (err_query_i) begin
			err_answer_o.valid <= 1'h1;
			if (do_pop)
				err_answer_o.code <= queue[rd_ptr].code;
			else
				err_answer_o.code <= ERR_NONE;
		end else begin
			err_answer_o.valid <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			panel_disp_o <= '0;
		end else begin
			panel_disp_o <= panel_err_i;
		end
	end

	assign err_count_o = count;

	a_empty_answer: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(err_query_i && count == ERR_CNT_RESET) |=>
			(err_answer_o.valid && err_answer_o.code == ERR_NONE))
		else $error("empty queue query did not answer zero");

	a_queue_pop: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(err_query_i && count != ERR_CNT_RESET && !remote_err_i.valid) |=>
			(count == $past(count) - 4'h1))
		else $error("error query did not remove an entry");

	a_queue_cap: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		count <= 4'(ERR_DEPTH))
		else $error("error queue count exceeded depth");

	a_full_drop: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(full && !err_query_i) |=> (count == 4'(ERR_DEPTH)))
		else $error("full queue changed without a read");

	a_push_count: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(remote_err_i.valid && !full && !err_query_i) |=>
			(count == $past(count) + 4'h1))
		else $error("remote error was not appended");

	a_overflow_code: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(remote_err_i.valid && at_last && !err_query_i) |=>
			(queue[wr_ptr - ERR_AW'(1)].code == ERR_OVERFLOW))
		else $error("last slot did not take the overflow code");

	a_answer_pulse: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!err_query_i |=> !err_answer_o.valid)
		else $error("error answer stood without a query");

	a_panel_copy: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		panel_err_i.valid |=> (panel_disp_o == $past(panel_err_i)))
		else $error("panel error did not reach the display");

	a_panel_unqueued: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(panel_err_i.valid && !remote_err_i.valid && !err_query_i) |=>
			(count == $past(count)))
		else $error("panel error entered the remote queue");

	////////////////////////////////////////////////////////////////////////
	// fixed system answers

	// no other language exists, so nothing needs storing
	assign lang_sel_o     = LANG_SCPI;
	assign version_o.year = VER_YEAR;
	assign version_o.rev  = VER_REV;
	assign trig_source_o  = SRC_BUS;

	////////////////////////////////////////////////////////////////////////
	// trigger subsystem

	logic any_abort;
	logic tran_go;
	logic acq_go;
	logic init_tran;
	logic init_acq;

	// power-on abort is covered by reset clearing the armed states
	assign any_abort = abort_cmd_i || recall_cmd_i || reset_cmd_i;
	assign init_tran = init_cmd_i && init_seq_i == SEQ_TRANSIENT;
	assign init_acq  = init_cmd_i && init_seq_i == SEQ_ACQUIRE;
	// bus trigger only counts when its sequence is armed
	assign tran_go = trig_cmd_i && trig_seq_i == SEQ_TRANSIENT
		&& tran_armed_o && !any_abort;
	assign acq_go  = trig_cmd_i && trig_seq_i == SEQ_ACQUIRE
		&& acq_armed_o && !any_abort;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tran_armed_o <= 1'h0;
		end else if (any_abort) begin
			tran_armed_o <= continuous_initiation_setting_i;
		end else if (tran_go) begin
			tran_armed_o <= continuous_initiation_setting_i;
		end else if (init_tran || continuous_initiation_setting_i) begin
			tran_armed_o <= 1'h1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			acq_armed_o <= 1'h0;
		end else if (any_abort || acq_go) begin
			acq_armed_o <= 1'h0;
		end else if (init_acq) begin
			acq_armed_o <= 1'h1;
		end
	end

	assign waiting_for_trigger_flag_o = tran_armed_o || acq_armed_o;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_change_o  <= 1'h0;
			level_restore_o <= 1'h0;
			meas_start_o    <= 1'h0;
			meas_func_o     <= TEQC_FN_VOLT;
		end else begin
			level_change_o  <= tran_go;
			level_restore_o <= any_abort;
			meas_start_o    <= acq_go;
			// function is expected to be chosen before the trigger
			if (acq_go)
				meas_func_o <= measurement_function_select_i;
		end
	end

	a_abort_clears: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(any_abort && !continuous_initiation_setting_i) |=>
			!waiting_for_trigger_flag_o)
		else $error("abort left waiting flag set");

	a_abort_rearm: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(any_abort && continuous_initiation_setting_i) |=>
			(tran_armed_o && level_restore_o))
		else $error("continuous abort did not re-arm transient");

	a_ignore_idle: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(trig_cmd_i && trig_seq_i == SEQ_TRANSIENT && !tran_armed_o) |=>
			!level_change_o)
		else $error("trigger acted on idle transient sequence");

	a_tran_fire: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(trig_cmd_i && trig_seq_i == SEQ_TRANSIENT && tran_armed_o
			&& !any_abort) |=> level_change_o)
		else $error("armed transient trigger did not fire");

	a_single_shot: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(tran_go && !continuous_initiation_setting_i) |=> !tran_armed_o)
		else $error("single-shot transient stayed armed");

	a_meas_fire: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		acq_go |=> (meas_start_o && !acq_armed_o))
		else $error("acquire trigger did not start measurement");

	a_abort_cancel: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		any_abort |=>
			(level_restore_o && !level_change_o && !meas_start_o))
		else $error("abort did not cancel trigger actions");

	a_acq_ignore: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(trig_cmd_i && trig_seq_i == SEQ_ACQUIRE && !acq_armed_o) |=>
			!meas_start_o)
		else $error("trigger acted on idle acquire sequence");

	a_tran_init: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(init_tran && !any_abort) |=> tran_armed_o)
		else $error("initiate did not arm the transient sequence");

	a_acq_init: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(init_acq && !any_abort && !acq_go) |=> acq_armed_o)
		else $error("initiate did not arm the acquire sequence");

	a_cont_hold: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(continuous_initiation_setting_i && !tran_go && !any_abort) |=>
			tran_armed_o)
		else $error("continuous initiation left transient idle");

	a_tran_pair: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(tran_go && acq_armed_o) |=> waiting_for_trigger_flag_o)
		else $error("waiting flag cleared with acquire still armed");

	a_cont_retrig: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(tran_go && continuous_initiation_setting_i) |=>
			(tran_armed_o && waiting_for_trigger_flag_o))
		else $error("continuous transient did not re-arm");

	a_meas_func: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		acq_go |=>
			(meas_func_o == $past(measurement_function_select_i)))
		else $error("measurement did not use the selected function");

endmodule : teqc_top

`default_nettype wire

/* File: testbench/teqc_ctrl_model.sv */
// controller model: issues one-cycle command pulses to the control block
`timescale 1ns/1ps
`default_nettype none
module teqc_ctrl_model
	import teqc_pkg::*;
(
	input  wire logic  ref_clk_i,
	output teqc_err_t  remote_err_o,
	output teqc_err_t  panel_err_o,
	output logic       query_o,
	output logic       init_o,
	output logic       trig_o,
	output logic [1:0] seq_o,
	output logic       abort_o,
	output logic       recall_o,
	output logic       rst_cmd_o
);
	initial begin
		remote_err_o = '0;
		panel_err_o = '0;
		{query_o, init_o, trig_o, abort_o, recall_o, rst_cmd_o} = '0;
		seq_o = 2'h0;
	end
	// one command per call; the selector is inverted once released
	task automatic send(input logic [2:0] k, input logic [1:0] s,
		input logic [15:0] c);
		@(negedge ref_clk_i);
		seq_o <= s;
		case (k)
		3'h0: remote_err_o <= '{1'b1, c};
		3'h1: panel_err_o <= '{1'b1, c};
		3'h2: query_o <= 1'b1;
		3'h3: init_o <= 1'b1;
		3'h4: trig_o <= 1'b1;
		3'h5: abort_o <= 1'b1;
		3'h6: recall_o <= 1'b1;
		default: rst_cmd_o <= 1'b1;
		endcase
		@(negedge ref_clk_i);
		remote_err_o <= '0;
		panel_err_o <= '0;
		{query_o, init_o, trig_o, abort_o, recall_o, rst_cmd_o} <= '0;
		seq_o <= ~s;
	endtask : send
endmodule : teqc_ctrl_model
`default_nettype wire

/* File: testbench/teqc_top_tb_top.sv */
// self-checking bench for the trigger and error queue control
`timescale 1ns/1ps
`default_nettype none
module teqc_top_tb_top
	import teqc_pkg::*;
;
	logic       ref_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       cont, q, ini, trg, abo, rcl, rcm, lc, lr, ms, ta, aa, waiting_for_trigger_flag;
	logic [1:0] sq, lang, src;
	logic [3:0] cnt;
	teqc_err_t  re, pe, ans, disp;
	teqc_ver_t  ver;
	teqc_func_t func, mf;
	int         n_errors = 0;
	int         tests_run = 0;
	int         i;
	always #25 ref_clk_i = ~ref_clk_i;
	teqc_ctrl_model ctrl (.ref_clk_i(ref_clk_i), .remote_err_o(re),
		.panel_err_o(pe), .query_o(q), .init_o(ini), .trig_o(trg),
		.seq_o(sq), .abort_o(abo), .recall_o(rcl), .rst_cmd_o(rcm));
	teqc_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .remote_err_i(re),
		.panel_err_i(pe), .err_query_i(q), .err_answer_o(ans),
		.panel_disp_o(disp), .err_count_o(cnt), .lang_sel_o(lang),
		.version_o(ver), .init_cmd_i(ini), .init_seq_i(sq),
		.trig_cmd_i(trg), .trig_seq_i(sq), .abort_cmd_i(abo),
		.recall_cmd_i(rcl), .reset_cmd_i(rcm),
		.continuous_initiation_setting_i(cont),
		.measurement_function_select_i(func), .trig_source_o(src),
		.level_change_o(lc), .level_restore_o(lr), .meas_start_o(ms),
		.meas_func_o(mf), .tran_armed_o(ta), .acq_armed_o(aa),
		.waiting_for_trigger_flag_o(waiting_for_trigger_flag));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [19:0] s,
		input logic [19:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// hang guard, far beyond the longest sequence
	initial begin
		#1000000;
		n_errors++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		cont = 1'b0;
		func = TEQC_FN_VOLT;
		repeat (2) @(negedge ref_clk_i);
		rst_i = 1'b0;
		chk("lang", 20'(lang), 20'(LANG_SCPI));
		chk("version", 20'(ver), {VER_YEAR, VER_REV});
		chk("source", 20'(src), 20'(SRC_BUS));
		chk("wtg reset", 20'(waiting_for_trigger_flag), 20'h0);
		ctrl.send(3'h2, 2'h0, 16'h0000);
		chk("empty", 20'(ans), 20'({1'b1, ERR_NONE}));
		for (i = 0; i <= ERR_DEPTH; i++)
			ctrl.send(3'h0, 2'h0, 16'(i + 1));
		chk("count", 20'(cnt), 20'(ERR_DEPTH));
		ctrl.send(3'h1, 2'h0, 16'h00AB);
		chk("panel", 20'(disp), 20'({1'b1, 16'h00AB}));
		chk("panel count", 20'(cnt), 20'(ERR_DEPTH));
		for (i = 0; i < ERR_DEPTH; i++) begin
			ctrl.send(3'h2, 2'h0, 16'h0000);
			chk("answer", 20'(ans), 20'({1'b1, (i < ERR_DEPTH - 1) ?
				16'(i + 1) : ERR_OVERFLOW}));
		end
		$display("error queue test done");
		ctrl.send(3'h4, SEQ_TRANSIENT, 16'h0000);
		chk("unarmed", 20'(lc), 20'h0);
		ctrl.send(3'h4, SEQ_ACQUIRE, 16'h0000);
		chk("unarmed acq", 20'(ms), 20'h0);
		ctrl.send(3'h3, SEQ_TRANSIENT, 16'h0000);
		chk("armed", 20'({ta, aa, waiting_for_trigger_flag}), 20'h5);
		ctrl.send(3'h3, SEQ_ACQUIRE, 16'h0000);
		ctrl.send(3'h4, SEQ_TRANSIENT, 16'h0000);
		chk("level", 20'({lc, ta, waiting_for_trigger_flag}), 20'h5);
		func = TEQC_FN_CURR;
		ctrl.send(3'h4, SEQ_ACQUIRE, 16'h0000);
		chk("meas", 20'({ms, mf}), 20'({1'b1, TEQC_FN_CURR}));
		chk("wtg clear", 20'(waiting_for_trigger_flag), 20'h0);
		for (i = 5; i < 8; i++) begin
			ctrl.send(3'h3, SEQ_TRANSIENT, 16'h0000);
			ctrl.send(3'h3, SEQ_ACQUIRE, 16'h0000);
			ctrl.send(3'(i), 2'h0, 16'h0000);
			chk("abort", 20'({lr, waiting_for_trigger_flag}), 20'h2);
		end
		$display("trigger test done");
		cont = 1'b1;
		ctrl.send(3'h5, 2'h0, 16'h0000);
		chk("cont abort", 20'({ta, waiting_for_trigger_flag}), 20'h3);
		ctrl.send(3'h4, SEQ_TRANSIENT, 16'h0000);
		chk("cont trig", 20'({lc, ta}), 20'h3);
		rst_i = 1'b1;
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		@(negedge ref_clk_i);
		chk("power on", 20'(ta), 20'h1);
		$display("continuous test done");
		report_and_stop();
	end
endmodule : teqc_top_tb_top
`default_nettype wire
